// File: common/csp_block_map.svh
`ifndef CSP_BLOCK_MAP_SVH
`define CSP_BLOCK_MAP_SVH

// upper four bits of the i2c slave address, below them come the three pins
`define CSP_I2C_ADDR_HI      4'h2
`define CSP_I2C_ADDR_W       7
// event status and mask width, one byte read per spi byte
`define CSP_EVENT_W          8
// control port byte width and bit counter width
`define CSP_BYTE_W           8
`define CSP_BITCNT_W         3
// sub-frames in one channel status block (192 frames of two)
`define CSP_BLOCK_SUBFRAMES  9'h180
`define CSP_SUBFRAME_CNT_W   9
// least master clock cycles of a high block-start input
`define CSP_START_MIN_CYC    2'h3
`define CSP_START_RUN_W      2

`endif

// File: common/csp_block_pkg.sv
package csp_block_pkg;

    // control port mode, one-hot
    typedef enum logic [1:0] {
        CSP_MODE_I2C = 2'b01,  // default after reset
        CSP_MODE_SPI = 2'b10   // entered on chip-select falling edge
    } csp_mode_e;

    // one byte as it moves over the control port
    typedef logic [7:0] csp_byte_t;

endpackage

// File: hdl/csp_spi_link.sv
`include "csp_block_map.svh"

// spi shifter, runs on the host's control port clock (idle high)
module csp_spi_link
    import csp_block_pkg::*;
(
    input  wire logic      controlPortClock, // link clock from host
    input  wire logic      linkRst,          // held reset from master domain
    input  wire logic      chipSelect_n,     // active low chip select pin
    input  wire logic      controlSerialIn,  // serial data from host
    input  wire csp_byte_t txByte,           // quasi-static read data
    output logic           controlSerialOut, // serial read data to host
    output csp_byte_t      rxByte,           // last complete byte
    output logic           rxToggle          // flips per complete byte
);

    logic [`CSP_BITCNT_W-1:0] rxCnt_reg;   // bits taken this byte
    logic [`CSP_BITCNT_W-1:0] txCnt_reg;   // bits sent this byte
    logic [`CSP_BYTE_W-2:0]   shift_reg;   // partial received byte
    logic                     frameRst;    // deselected or held

    // a deselected port is held idle, partial bytes are dropped
    assign frameRst = linkRst | chipSelect_n;

    always_ff @(posedge controlPortClock or posedge frameRst) begin
        if (frameRst) begin
            rxCnt_reg <= '0;
            shift_reg <= '0;
        end else begin
            rxCnt_reg <= rxCnt_reg + 1'b1;
            shift_reg <= {shift_reg[`CSP_BYTE_W-3:0], controlSerialIn};
        end
    end

    // byte completion, toggle kept across frames for the crossing
    always_ff @(posedge controlPortClock or posedge linkRst) begin
        if (linkRst) begin
            rxByte   <= '0;
            rxToggle <= 1'b0;
        end else if (!chipSelect_n && (&rxCnt_reg)) begin
            rxByte   <= {shift_reg, controlSerialIn};
            rxToggle <= ~rxToggle;
        end
    end

    // shift out on falling edge, msb first
    always_ff @(negedge controlPortClock or posedge frameRst) begin
        if (frameRst) begin
            txCnt_reg        <= '0;
            controlSerialOut <= 1'b0;
        end else begin
            txCnt_reg        <= txCnt_reg + 1'b1;
            controlSerialOut <= txByte[~txCnt_reg];
        end
    end

endmodule // csp_spi_link

// File: hdl/csp_block_top.sv
// Function
// - chip select falling edge selects spi mode
// - otherwise i2c, pin is address bit zero
// - spi transfers only while chip select low
// - spi data enters on address bit one
// - spi read data driven on data pin
// - host clock shifts data in and out
// - i2c address formed from address pins
// - only unmasked events assert, causes readable
// - event pin polarity and drive selectable
// - event pin holds until status read clears
// - block start output high first sub-frame
// - three-cycle high input restarts next block
// - audio clocks selectable input or output
`include "csp_block_map.svh"

module csp_block_top
    import csp_block_pkg::*;
(
    input  wire logic                        ref_clk,          // master clock
    input  wire logic                        rst,              // sync reset, high
    input  wire logic                        controlPortClock, // host serial clock
    input  wire logic                        addressBitZero,   // address 0 / cs pin
    input  wire logic                        controlSerialIn,  // address 1 / data pin
    input  wire logic                        addressBitTwo,    // address 2 pin
    output logic                             controlSerialOut, // data pin out level
    output logic                             ctlDataOe_n,      // data pin drive, low
    output logic                             spiMode,          // spi mode selected
    output logic [`CSP_I2C_ADDR_W-1:0]       i2cSlaveAddr,     // i2c slave address
    output csp_byte_t                        rxData,           // received spi byte
    output logic                             rxValid,          // rxData new, pulse
    input  wire logic [`CSP_EVENT_W-1:0]     eventRaw,         // event pulses
    input  wire logic [`CSP_EVENT_W-1:0]     eventMask,        // 1 = unmasked
    input  wire logic                        eventActiveHigh,  // pin polarity
    input  wire logic                        eventOpenDrain,   // open drain drive
    output logic [`CSP_EVENT_W-1:0]          eventStatus,      // sticky causes
    output logic                             eventPinOut,      // event pin level
    output logic                             eventPinOe_n,     // event drive, low
    input  wire logic                        subframeTick,     // sub-frame start
    input  wire logic                        blkStartIsOutput, // pin direction
    input  wire logic                        csBlockStartIn,   // block start pin in
    output logic                             csBlockStartOut,  // block start out
    output logic                             csBlockStartOe_n, // block drive, low
    output logic                             firstSubframe,    // sub-frame 0 now
    output logic                             blockRestart,     // forced new block
    input  wire logic                        bitClkIsOutput,   // bit clock dir
    input  wire logic                        wordClkIsOutput,  // word clock dir
    input  wire logic                        bitClkGen,        // internal bit clock
    input  wire logic                        wordClkGen,       // internal word clock
    input  wire logic                        audioBitClockIn,  // bit clock pin in
    input  wire logic                        audioWordClockIn, // word clock pin in
    output logic                             audioBitClockOut, // bit clock pin out
    output logic                             audioBitClockOe_n,// bit clock drive
    output logic                             audioWordClockOut,// word clock pin out
    output logic                             audioWordClockOe_n,// word clock drive
    input  wire logic                        audioSerialIn,    // audio data pin
    output logic                             audioBitClock,    // synced bit clock
    output logic                             audioWordClock,   // synced word clock
    output logic                             audioData         // synced audio data
);

    // pin synchronisers: stage one feeds stage two only
    logic [6:0]            syncA_reg;      // first stage of pin syncs
    logic [6:0]            syncB_reg;      // second stage, used by logic
    logic                  adz0Prev_reg;   // previous synced cs level
    logic                  adz0Fall;       // falling edge seen
    csp_mode_e             mode_reg;       // control port mode
    csp_mode_e             mode_next;      // next mode
    logic                  selected;       // spi and cs low
    logic                  linkRst_reg;    // holds link logic idle
    csp_byte_t             linkByte;       // byte from link domain
    logic                  linkToggle;     // toggle from link domain
    logic [2:0]            tglSync_reg;    // toggle sync and edge stage
    logic                  byteDone;       // one byte complete
    logic [`CSP_EVENT_W-1:0] snapshot_reg; // status as read by host
    logic [`CSP_EVENT_W-1:0] status_next;  // sticky status next
    logic [`CSP_EVENT_W-1:0] clearBits;    // bits cleared by a read
    logic                  eventAct;       // unmasked cause pending
    logic                  eventActive_reg;// pin asserted state
    logic                  eventLevel;     // electrical level of pin
    logic [`CSP_SUBFRAME_CNT_W-1:0] sfCnt_reg;  // sub-frame in block
    logic [`CSP_SUBFRAME_CNT_W-1:0] sfCntWrap;  // following sub-frame
    logic                  frameBoundary;  // next sub-frame opens frame
    logic [`CSP_START_RUN_W-1:0] startRun_reg; // high run length
    logic                  startHeld;      // held long enough
    logic                  pending_reg;    // restart waiting
    logic                  pending_next;   // restart waiting next
    logic                  doRestart;      // restart this tick

    // sync order: cs, address 1, address 2, block start, audio data, bit clock, word clock
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            syncA_reg <= '0;
            syncB_reg <= '0;
        end else begin
            syncA_reg <= {audioWordClockIn, audioBitClockIn, audioSerialIn, csBlockStartIn,
                          addressBitTwo, controlSerialIn, addressBitZero};
            syncB_reg <= syncA_reg;
        end
    end

    // edge stage for the cs pin, reads the second stage only
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            adz0Prev_reg <= 1'b0;
        end else begin
            adz0Prev_reg <= syncB_reg[0];
        end
    end

    assign adz0Fall = adz0Prev_reg & ~syncB_reg[0];

    // mode selection
    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            CSP_MODE_I2C: begin
                if (adz0Fall) begin
                    mode_next = CSP_MODE_SPI;
                end
            end
            CSP_MODE_SPI: begin
                mode_next = CSP_MODE_SPI;
            end
            // illegal code recovers to default
            default: begin
                mode_next = CSP_MODE_I2C;
            end
        endcase
    end

    // mode register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_reg <= CSP_MODE_I2C;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // chip select active low in spi mode
    assign selected = (mode_reg == CSP_MODE_SPI) & ~syncB_reg[0];

    // mode flags, link hold and data pin drive
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            spiMode     <= 1'b0;
            linkRst_reg <= 1'b1;
            ctlDataOe_n <= 1'b1;
        end else begin
            spiMode     <= (mode_next == CSP_MODE_SPI);
            linkRst_reg <= (mode_reg != CSP_MODE_SPI);
            ctlDataOe_n <= ~selected;
        end
    end

    // address from pins, cs pin is bit zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            i2cSlaveAddr <= '0;
        end else if (mode_reg == CSP_MODE_I2C) begin
            i2cSlaveAddr <= {`CSP_I2C_ADDR_HI, syncB_reg[2], syncB_reg[1],
                             syncB_reg[0]};
        end
    end

    // serial shifter on the host's clock
    csp_spi_link u_link (
        .controlPortClock (controlPortClock),
        .linkRst          (linkRst_reg),
        .chipSelect_n     (addressBitZero),
        .controlSerialIn  (controlSerialIn),
        .txByte           (snapshot_reg),
        .controlSerialOut (controlSerialOut),
        .rxByte           (linkByte),
        .rxToggle         (linkToggle)
    );

    // toggle crossing, third stage for the edge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tglSync_reg <= '0;
        end else begin
            tglSync_reg <= {tglSync_reg[1:0], linkToggle};
        end
    end

    // byte boundary seen in master domain
    assign byteDone = tglSync_reg[2] ^ tglSync_reg[1];

    // received byte capture, byte is stable for a whole byte time
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rxData  <= '0;
            rxValid <= 1'b0;
        end else begin
            rxValid <= byteDone;
            if (byteDone) begin
                rxData <= linkByte;
            end
        end
    end

    // snapshot frozen while selected so the link reads a still word
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            snapshot_reg <= '0;
        end else if (!selected) begin
            snapshot_reg <= eventStatus;
        end
    end

    // a completed read clears the bits it returned
    assign clearBits   = byteDone ? snapshot_reg : '0;
    // new events win over the clear
    assign status_next = (eventStatus & ~clearBits) | eventRaw;

    assign eventAct = |(status_next & eventMask);

    assign eventLevel = eventAct ~^ eventActiveHigh;

    // sticky status and event pin
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            eventStatus     <= '0;
            eventActive_reg <= 1'b0;
            eventPinOut     <= 1'b0;
            eventPinOe_n    <= 1'b1;
        end else begin
            eventStatus     <= status_next;
            eventActive_reg <= eventAct;
            // open drain drives only a low level
            eventPinOut     <= eventOpenDrain ? 1'b0 : eventLevel;
            eventPinOe_n    <= eventOpenDrain ? eventLevel : 1'b0;
        end
    end

    // block position arithmetic
    assign sfCntWrap = (sfCnt_reg == `CSP_BLOCK_SUBFRAMES - 1'b1) ? '0
                                                                : sfCnt_reg + 1'b1;
    assign frameBoundary = ~sfCntWrap[0];
    assign startHeld     = (startRun_reg == `CSP_START_MIN_CYC);
    assign doRestart     = subframeTick & frameBoundary & pending_reg;
    // held request wins over its own consumption
    assign pending_next  = (startHeld & ~blkStartIsOutput)
                         | (pending_reg & ~doRestart);

    // high run length on the block start input
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            startRun_reg <= '0;
        end else if (!syncB_reg[3] || blkStartIsOutput) begin
            startRun_reg <= '0;
        end else if (!startHeld) begin
            startRun_reg <= startRun_reg + 1'b1;
        end
    end

    // next frame opens a new block
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sfCnt_reg    <= `CSP_BLOCK_SUBFRAMES - 1'b1;
            pending_reg  <= 1'b0;
            blockRestart <= 1'b0;
        end else begin
            pending_reg  <= pending_next;
            blockRestart <= doRestart;
            if (doRestart) begin
                sfCnt_reg <= '0;
            end else if (subframeTick) begin
                sfCnt_reg <= sfCntWrap;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            firstSubframe    <= 1'b0;
            csBlockStartOut  <= 1'b0;
            csBlockStartOe_n <= 1'b1;
        end else begin
            firstSubframe    <= (sfCnt_reg == '0);
            csBlockStartOut  <= blkStartIsOutput & (sfCnt_reg == '0);
            csBlockStartOe_n <= ~blkStartIsOutput;
        end
    end

    // audio clock direction and synced views
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            audioBitClockOut   <= 1'b0;
            audioBitClockOe_n  <= 1'b1;
            audioWordClockOut  <= 1'b0;
            audioWordClockOe_n <= 1'b1;
            audioBitClock      <= 1'b0;
            audioWordClock     <= 1'b0;
            audioData          <= 1'b0;
        end else begin
            audioBitClockOut   <= bitClkGen;
            audioBitClockOe_n  <= ~bitClkIsOutput;
            audioWordClockOut  <= wordClkGen;
            audioWordClockOe_n <= ~wordClkIsOutput;
            audioBitClock      <= bitClkIsOutput ? bitClkGen : syncB_reg[5];
            audioWordClock     <= wordClkIsOutput ? wordClkGen : syncB_reg[6];
            audioData          <= syncB_reg[4];
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // three held cycles of the block start input
    sequence seqStartHeld;
        (!blkStartIsOutput && syncB_reg[3])[*3];
    endsequence

    // a waiting restart meets a frame opening
    sequence seqRestartTick;
        pending_reg && subframeTick && frameBoundary;
    endsequence

    chk_spi_entry: assert property (adz0Fall |=> spiMode && mode_reg == CSP_MODE_SPI)
        else $error("falling edge did not select spi");
    chk_spi_sticky: assert property (mode_reg == CSP_MODE_SPI |=> spiMode)
        else $error("spi mode left without reset");
    chk_i2c_default: assert property (!spiMode && !adz0Fall |=> !spiMode)
        else $error("left i2c mode without an edge");
    chk_addr_form: assert property (mode_reg == CSP_MODE_I2C |=>
        i2cSlaveAddr == {`CSP_I2C_ADDR_HI, $past(syncB_reg[2:0])})
        else $error("i2c address not taken from pins");
    // data pin driven only while selected
    chk_sdo_drive: assert property (!ctlDataOe_n |-> $past(spiMode) && $past(!syncB_reg[0]))
        else $error("data pin driven outside a selected spi transfer");
    chk_byte_spi: assert property (rxValid |-> spiMode)
        else $error("byte accepted outside spi mode");
    // unmasked event reaches the pin in one cycle, still asserted the cycle after
    chk_event_pin: assert property (|(eventRaw & eventMask) |=>
        ##1 eventActive_reg && (eventOpenDrain || eventPinOut == $past(eventActiveHigh)))
        else $error("unmasked event did not assert pin");
    // asserted pin waits for a read
    chk_event_hold: assert property (eventActive_reg && !byteDone && $stable(eventMask)
        |=> eventActive_reg)
        else $error("event pin dropped without a status read");
    chk_open_drain: assert property ($past(eventOpenDrain) && !eventPinOe_n |-> !eventPinOut)
        else $error("open drain event pin drove high");
    // output high only at sub-frame zero
    chk_block_out: assert property (csBlockStartOut |-> $past(sfCnt_reg) == '0)
        else $error("block start high outside first sub-frame");
    chk_start_arm: assert property (seqStartHeld ##1 !blkStartIsOutput |=> pending_reg)
        else $error("held block start did not arm restart");
    chk_restart_go: assert property (seqRestartTick |=> sfCnt_reg == '0 && blockRestart)
        else $error("restart did not open a new block");

endmodule // csp_block_top

// File: tb/csp_spi_host.sv
// spi host model: makes the link clock only inside frames, idle high
module csp_spi_host (
    output logic      controlPortClock, // link clock, 80 ns period in frames
    output logic      chipSelect_n,     // chip select, also address bit zero
    output logic      controlSerialIn,  // host data, also address bit one
    input  wire logic controlSerialOut  // read data from the device
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle levels: clock high, chip select high
    initial begin
        controlPortClock = 1'b1;
        chipSelect_n     = 1'b1;
        controlSerialIn  = 1'b0;
    end
    // static pin levels while the port is in i2c mode
    task automatic hold(input logic a0, input logic a1);
        chipSelect_n    <= a0;
        controlSerialIn <= a1;
    endtask
    // frame: data out on fall, sampled on rise, msb first
    task automatic xfer(input logic [7:0] txd, input int nBits, output logic [7:0] rxd);
        rxd          = 8'h00;
        chipSelect_n = 1'b0;
        #47;
        for (int i = 7; i > 7 - nBits; i--) begin
            controlPortClock = 1'b0;
            controlSerialIn  = txd[i];
            #40;
            controlPortClock = 1'b1;
            rxd[i]           = controlSerialOut;
            #40;
        end
        chipSelect_n    = 1'b1;
        // released data line shows the inverse of its last level
        controlSerialIn = ~controlSerialIn;
        #40;
    endtask
endmodule // csp_spi_host

// File: tb/csp_block_top_tb_top.sv
`include "csp_block_map.svh"
// bench: drives pins, runs the spi host, compares ports with expectations
module csp_block_top_tb_top
    import csp_block_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0, rst = 1'b1, tickOn = 1'b0, drove = 1'b0; // clock, reset, sub-frame tick enable, drive monitor
    logic controlPortClock, addressBitZero, controlSerialIn, addressBitTwo = 1'b0;
    logic eventActiveHigh = 1'b1, eventOpenDrain = 1'b0, subframeTick = 1'b0;
    logic blkStartIsOutput = 1'b0, csBlockStartIn = 1'b0, bitClkIsOutput = 1'b0;
    logic wordClkIsOutput = 1'b0, bitClkGen = 1'b0, wordClkGen = 1'b0, audioSerialIn = 1'b0;
    logic audioBitClockIn = 1'b0, audioWordClockIn = 1'b0;
    logic [1:0] phase = 2'h0;                  // sub-frame tick divider
    logic [`CSP_EVENT_W-1:0] eventRaw = 8'h00, eventMask = 8'h00, eventStatus;
    logic controlSerialOut, ctlDataOe_n, spiMode, rxValid, eventPinOut, eventPinOe_n;
    logic csBlockStartOut, csBlockStartOe_n, firstSubframe, blockRestart, audioData;
    logic audioBitClockOut, audioBitClockOe_n, audioWordClockOut, audioWordClockOe_n;
    logic audioBitClock, audioWordClock;
    logic [`CSP_I2C_ADDR_W-1:0] i2cSlaveAddr;  // slave address seen
    csp_byte_t rxData, rxSeen, rd;             // received, recorded and host read bytes
    int failures = 0, compares = 0, rxCount = 0, restarts = 0, hi, ticks;

    always #2.5 ref_clk = ~ref_clk;

    csp_block_top i_csp_block_top (
        .ref_clk, .rst, .controlPortClock, .addressBitZero, .controlSerialIn, .addressBitTwo,
        .controlSerialOut, .ctlDataOe_n, .spiMode, .i2cSlaveAddr, .rxData, .rxValid,
        .eventRaw, .eventMask, .eventActiveHigh, .eventOpenDrain, .eventStatus, .eventPinOut,
        .eventPinOe_n, .subframeTick, .blkStartIsOutput, .csBlockStartIn, .csBlockStartOut,
        .csBlockStartOe_n, .firstSubframe, .blockRestart, .bitClkIsOutput, .wordClkIsOutput,
        .bitClkGen, .wordClkGen, .audioBitClockIn, .audioWordClockIn, .audioBitClockOut,
        .audioBitClockOe_n, .audioWordClockOut, .audioWordClockOe_n, .audioSerialIn,
        .audioBitClock, .audioWordClock, .audioData
    );
    csp_spi_host i_csp_spi_host (
        .controlPortClock, .chipSelect_n(addressBitZero), .controlSerialIn, .controlSerialOut
    );

    // sub-frame tick every fourth cycle, byte and restart recorders
    always @(posedge ref_clk) begin
        phase        <= tickOn ? phase + 2'h1 : 2'h0;
        subframeTick <= tickOn && phase == 2'h3;
        if (rxValid === 1'b1) begin
            rxSeen  <= rxData;
            rxCount <= rxCount + 1;
        end
        if (blockRestart === 1'b1) restarts <= restarts + 1;
        if (addressBitZero === 1'b0 && ctlDataOe_n === 1'b0) drove <= 1'b1;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // bounded wait for a flag going high, checked after each edge
    task automatic wait_sig(input string name, ref logic s, input int lim);
        for (int n = 0; n < lim && s !== 1'b1; n++) @(posedge ref_clk) #1;
        check(name, 1, s);
        if (s !== 1'b1) print_verdict();
    endtask
    // cycles the block start output stays high, ticks from one rise to the next
    task automatic measure();
        int n;
        n = 0; hi = 0; ticks = 0;
        while (csBlockStartOut !== 1'b1 && n++ < 2000) @(posedge ref_clk) #1;
        while (csBlockStartOut === 1'b1 && hi < 99) begin
            ticks += subframeTick;
            hi++;
            @(posedge ref_clk) #1;
        end
        while (csBlockStartOut !== 1'b1 && n++ < 4000) begin
            ticks += subframeTick;
            @(posedge ref_clk) #1;
        end
    endtask

    // a hang ends the run as a mismatch
    initial begin
        #200000;
        failures++;
        print_verdict();
    end

    initial begin
        cyc(16);
        rst <= 1'b0;
        cyc(6);
        for (int k = 0; k < 4; k++) begin
            cyc(1);
            i_csp_spi_host.hold(1'b1, k[0]);
            addressBitTwo <= k[1];
            cyc(8);
            #1 check("i2cSlaveAddr", {`CSP_I2C_ADDR_HI, k[1:0], 1'b1}, i2cSlaveAddr);
        end
        check("spiMode", 0, spiMode);
        // masked cause alone, then an unmasked one
        cyc(1);
        eventMask <= 8'h01;
        eventRaw  <= 8'h08;
        cyc(1);
        eventRaw  <= 8'h00;
        cyc(2);
        #1 check("eventStatus", 8'h08, eventStatus);
        check("eventPinOut", 0, eventPinOut);
        cyc(1);
        eventRaw <= 8'h01;
        cyc(1);
        eventRaw <= 8'h00;
        cyc(30);
        #1 check("eventPinOut", 1, eventPinOut);
        check("eventPinOe_n", 0, eventPinOe_n);
        cyc(1);
        eventActiveHigh <= 1'b0;
        eventOpenDrain  <= 1'b1;
        cyc(3);
        #1 check("eventPinOut", 0, eventPinOut);
        check("eventPinOe_n", 0, eventPinOe_n);
        // chip select falls once: spi mode, address frozen
        cyc(1);
        i_csp_spi_host.hold(1'b0, 1'b1);
        wait_sig("spiMode", spiMode, 8);
        cyc(1);
        i_csp_spi_host.hold(1'b1, 1'b0);
        addressBitTwo <= 1'b0;
        cyc(8);
        #1 check("i2cSlaveAddr", {`CSP_I2C_ADDR_HI, 2'b11}, i2cSlaveAddr[6:1]);
        check("spiMode", 1, spiMode);
        i_csp_spi_host.xfer(8'hA5, 8, rd);
        check("readByte", 8'h09, rd);
        cyc(8);
        #1 check("rxData", 8'hA5, rxSeen);
        check("eventStatus", 0, eventStatus);
        check("eventPinOe_n", 1, eventPinOe_n);
        check("drove", 1, drove);
        check("ctlDataOe_n", 1, ctlDataOe_n);
        i_csp_spi_host.xfer(8'hFF, 4, rd);
        i_csp_spi_host.xfer(8'h3C, 8, rd);
        check("readByte", 8'h00, rd);
        cyc(8);
        #1 check("rxCount", 2, rxCount);
        check("rxData", 8'h3C, rxSeen);
        // block start as output, then as input
        cyc(1);
        blkStartIsOutput <= 1'b1;
        tickOn           <= 1'b1;
        measure();
        check("startHigh", 4, hi);
        check("blockTicks", `CSP_BLOCK_SUBFRAMES, ticks);
        check("csBlockStartOe_n", 0, csBlockStartOe_n);
        cyc(1);
        blkStartIsOutput <= 1'b0;
        csBlockStartIn   <= 1'b1;
        cyc(2);
        csBlockStartIn   <= 1'b0;
        cyc(40);
        #1 check("restarts", 0, restarts);
        cyc(1);
        csBlockStartIn <= 1'b1;
        cyc(3);
        csBlockStartIn <= 1'b0;
        wait_sig("blockRestart", blockRestart, 60);
        cyc(1);
        #1 check("firstSubframe", 1, firstSubframe);
        check("csBlockStartOe_n", 1, csBlockStartOe_n);
        // audio clocks: both directions, pin and internal levels differ
        for (int d = 0; d < 2; d++) begin
            cyc(1);
            bitClkIsOutput   <= d[0];
            wordClkIsOutput  <= d[0];
            bitClkGen        <= 1'b1;
            audioWordClockIn <= 1'b1;
            audioSerialIn    <= d[0];
            cyc(5);
            #1 check("audioBitClock", d, audioBitClock);
            check("audioWordClock", d == 0, audioWordClock);
            check("audioBitClockOe_n", d == 0, audioBitClockOe_n);
            check("audioWordClockOe_n", d == 0, audioWordClockOe_n);
            check("audioData", d, audioData);
            check("audioBitClockOut", 1, audioBitClockOut);
            check("audioWordClockOut", 0, audioWordClockOut);
        end
        print_verdict();
    end
endmodule // csp_block_top_tb_top
